// ===== mcrt_map.vh
// register map, field positions and timing constants for the metering configuration tail
// assumes inclusion by mcrt_regs.v only; definitions only
`ifndef MCRT_MAP_VH
`define MCRT_MAP_VH

// register indices; byte address is four times the index
`define MCRT_IDX_CRC_FORCE 12'h4b4
`define MCRT_IDX_CRC_OPT 12'h4b5
`define MCRT_IDX_TEMP_CTRL 12'h4b6
`define MCRT_IDX_TEMP_VAL 12'h4b7
`define MCRT_IDX_GAIN 12'h4b9
`define MCRT_IDX_CONV_OFF 12'h4ba
`define MCRT_IDX_REACT_OFF 12'h4e0
`define MCRT_IDX_EVT_STATUS 12'h4f0
`define MCRT_IDX_EVT_MASK 12'h4f1

// writable bit masks; reserved bits read zero
`define MCRT_MASK_CRC_OPT 16'hffff
`define MCRT_MASK_TEMP_CTRL 16'h0007
`define MCRT_MASK_TEMP_VAL 16'h0fff
`define MCRT_MASK_GAIN 16'h3fff
`define MCRT_MASK_CONV_OFF 16'h007f
`define MCRT_MASK_REACT_OFF 16'h0001
`define MCRT_MASK_EVT 16'h0003

// field positions
`define MCRT_BIT_CRC_FORCE 0
`define MCRT_BIT_TEMP_START 3
`define MCRT_BIT_TEMP_EN 2
`define MCRT_TEMP_AVG_HI 1
`define MCRT_TEMP_AVG_LO 0
`define MCRT_BIT_REACT_OFF 0
`define MCRT_BIT_EVT_TEMP_RDY 0
`define MCRT_BIT_EVT_CRC_DONE 1

// averaging codes and their log2 sample counts
`define MCRT_AVG_1 2'h0
`define MCRT_AVG_256 2'h1
`define MCRT_AVG_512 2'h2
`define MCRT_SHIFT_1 4'h0
`define MCRT_SHIFT_256 4'h8
`define MCRT_SHIFT_512 4'h9
`define MCRT_SHIFT_1024 4'ha

// gain codes and resulting shift (gain = 1 << shift)
`define MCRT_GAIN_X1 2'h0
`define MCRT_GAIN_X2 2'h1
`define MCRT_SHL_X1 2'h0
`define MCRT_SHL_X2 2'h1
`define MCRT_SHL_X4 2'h2

// timing
`define MCRT_CLK_MHZ 100
`define MCRT_TEMP_PERIOD_US 1000

// reset values
`define MCRT_RST_16 16'h0000
`define MCRT_RST_32 32'h0000_0000

`endif

// ===== mcrt_regs.v
// metering configuration tail: crc selection, temperature sensor control, converter gain,
// converter shutdown and total reactive switch, on an apb slave with one event interrupt
// assumes the sensor, crc engine and converters sit on clk_i; no synchroniser needed
//
// Summary of operation
// - crc option bits 8 and 7 include reactive and active no-load thresholds
// - crc option bits 6 to 3 include surge cycles, surge level, sag cycles, sag level
// - crc option bits 2 to 0 include event enable, irq enable words 1 and 0
// - writing one to temperature start launches a reading; bit clears itself
// - manual reading delivered within 1 ms, flagged by temperature-ready event
// - temperature enable bit 2 powers the sensor; clear keeps it off except while a conversion, manual or already running, is in progress
// - averaging field picks 1, 256, 512 or 1024 samples, one per ms
// - 12-bit temperature result in bits 11:0, upper bits read zero
// - gain code 00 is x1, 01 is x2, 10 and 11 are x4
// - seven two-bit gain fields from volt c at 13:12 down to current a
// - converter shutdown bits 6 to 0 each turn one channel converter off
// - reactive off bit 0 stops total reactive power calculation
// - writing crc force bit 0 starts the crc; completion sets crc-done flag
`timescale 1ns/1ps
`include "mcrt_map.vh"

module mcrt_regs #(
  parameter ADDR_W = 16,
  parameter MS_CYCLES = `MCRT_TEMP_PERIOD_US * `MCRT_CLK_MHZ
) (
  input wire clk_i,
  input wire nrst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [ADDR_W-1:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  output wire irq_o,
  output wire [15:0] crc_select_o,
  output wire crc_start_o,
  input wire crc_done_i,
  output wire temp_sensor_en_o,
  output wire temp_conv_start_o,
  input wire temp_sample_valid_i,
  input wire [11:0] temp_sample_i,
  output wire [13:0] gain_code_o,
  output wire [13:0] gain_shift_o,
  output wire [6:0] converter_off_o,
  output wire total_reactive_off_o
);

  localparam ST_IDLE = 2'b01;
  localparam ST_CONV = 2'b10;

  // register word index from the byte address
  wire [ADDR_W-3:0] idx = paddr_i[ADDR_W-1:2];
  wire sel_crc_force = (idx == `MCRT_IDX_CRC_FORCE);
  wire sel_crc_opt = (idx == `MCRT_IDX_CRC_OPT);
  wire sel_temp_ctrl = (idx == `MCRT_IDX_TEMP_CTRL);
  wire sel_temp_val = (idx == `MCRT_IDX_TEMP_VAL);
  wire sel_gain = (idx == `MCRT_IDX_GAIN);
  wire sel_conv_off = (idx == `MCRT_IDX_CONV_OFF);
  wire sel_react_off = (idx == `MCRT_IDX_REACT_OFF);
  wire sel_evt_status = (idx == `MCRT_IDX_EVT_STATUS);
  wire sel_evt_mask = (idx == `MCRT_IDX_EVT_MASK);
  wire mapped = sel_crc_force | sel_crc_opt | sel_temp_ctrl | sel_temp_val | sel_gain |
    sel_conv_off | sel_react_off | sel_evt_status | sel_evt_mask;

  wire access = psel_i & penable_i;
  wire setup = psel_i & ~penable_i;
  wire wr = access & pwrite_i & mapped;
  wire [15:0] wdata = pwdata_i[15:0];

  reg [15:0] crc_opt_reg;
  reg [15:0] crc_opt_next;
  reg crc_start_reg;
  reg [2:0] temp_ctrl_reg;
  reg [2:0] temp_ctrl_next;
  reg start_pend_reg;
  reg start_pend_next;
  reg [11:0] temp_val_reg;
  reg [11:0] temp_val_next;
  reg [13:0] gain_reg;
  reg [13:0] gain_next;
  reg [6:0] conv_off_reg;
  reg [6:0] conv_off_next;
  reg react_off_reg;
  reg react_off_next;
  reg [1:0] evt_status_reg;
  reg [1:0] evt_status_next;
  reg [1:0] evt_mask_reg;
  reg [1:0] evt_mask_next;
  reg [31:0] prdata_reg;
  reg [31:0] prdata_next;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg manual_reg;
  reg manual_next;
  reg [21:0] acc_reg;
  reg [21:0] acc_next;
  reg [10:0] cnt_reg;
  reg [10:0] cnt_next;
  reg [16:0] tick_cnt_reg;
  reg [16:0] tick_cnt_next;
  reg conv_start_reg;
  reg conv_start_next;
  reg temp_rdy_evt;
  reg [3:0] avg_shift;
  reg [21:0] acc_sum;
  reg [10:0] cnt_limit;

  wire sensor_en = temp_ctrl_reg[`MCRT_BIT_TEMP_EN];
  wire [1:0] avg_sel = temp_ctrl_reg[`MCRT_TEMP_AVG_HI:`MCRT_TEMP_AVG_LO];
  wire ms_tick = (tick_cnt_reg == MS_CYCLES[16:0] - 17'h0_0001);

  // plain configuration registers
  always @* begin
    crc_opt_next = crc_opt_reg;
    temp_ctrl_next = temp_ctrl_reg;
    gain_next = gain_reg;
    conv_off_next = conv_off_reg;
    react_off_next = react_off_reg;
    evt_mask_next = evt_mask_reg;
    if (wr && sel_crc_opt) begin
      crc_opt_next = wdata & `MCRT_MASK_CRC_OPT;
    end
    if (wr && sel_temp_ctrl) begin
      temp_ctrl_next = wdata[2:0];
    end
    if (wr && sel_gain) begin
      gain_next = wdata[13:0];
    end
    if (wr && sel_conv_off) begin
      conv_off_next = wdata[6:0];
    end
    if (wr && sel_react_off) begin
      react_off_next = wdata[`MCRT_BIT_REACT_OFF];
    end
    if (wr && sel_evt_mask) begin
      evt_mask_next = wdata[1:0];
    end
  end

  // sticky events; a set in the same cycle as a write-one clear wins
  always @* begin
    evt_status_next = evt_status_reg;
    if (wr && sel_evt_status) begin
      evt_status_next = evt_status_reg & ~wdata[1:0];
    end
    if (temp_rdy_evt) begin
      evt_status_next[`MCRT_BIT_EVT_TEMP_RDY] = 1'b1;
    end
    if (crc_done_i) begin
      evt_status_next[`MCRT_BIT_EVT_CRC_DONE] = 1'b1;
    end
  end

  // read data captured in the setup phase so the bus sees a flop output
  always @* begin
    prdata_next = prdata_reg;
    if (setup) begin
      prdata_next = `MCRT_RST_32;
      if (sel_crc_opt) begin
        prdata_next[15:0] = crc_opt_reg;
      end
      if (sel_temp_ctrl) begin
        prdata_next[`MCRT_BIT_TEMP_START] = start_pend_reg;
        prdata_next[2:0] = temp_ctrl_reg;
      end
      if (sel_temp_val) begin
        prdata_next[11:0] = temp_val_reg;
      end
      if (sel_gain) begin
        prdata_next[13:0] = gain_reg;
      end
      if (sel_conv_off) begin
        prdata_next[6:0] = conv_off_reg;
      end
      if (sel_react_off) begin
        prdata_next[0] = react_off_reg;
      end
      if (sel_evt_status) begin
        prdata_next[1:0] = evt_status_reg;
      end
      if (sel_evt_mask) begin
        prdata_next[1:0] = evt_mask_reg;
      end
    end
  end

  // averaging depth
  always @* begin
    case (avg_sel)
      `MCRT_AVG_1: avg_shift = `MCRT_SHIFT_1;
      `MCRT_AVG_256: avg_shift = `MCRT_SHIFT_256;
      `MCRT_AVG_512: avg_shift = `MCRT_SHIFT_512;
      default: avg_shift = `MCRT_SHIFT_1024;
    endcase
    cnt_limit = 11'h001 << avg_shift;
    acc_sum = acc_reg + {10'h000, temp_sample_i};
  end

  // temperature sequencer: one conversion per ms tick, or one on manual start
  always @* begin
    state_next = state_reg;
    manual_next = manual_reg;
    acc_next = acc_reg;
    cnt_next = cnt_reg;
    temp_val_next = temp_val_reg;
    start_pend_next = start_pend_reg;
    conv_start_next = 1'b0;
    temp_rdy_evt = 1'b0;
    tick_cnt_next = sensor_en ? (ms_tick ? 17'h0_0000 : tick_cnt_reg + 17'h0_0001) : 17'h0_0000;
    if (wr && sel_temp_ctrl) begin
      // a new setting restarts the running average, except in a cycle where a mid-average sample is accumulated
      acc_next = 22'h00_0000;
      cnt_next = 11'h000;
      if (wdata[`MCRT_BIT_TEMP_START]) begin
        start_pend_next = 1'b1;
      end
    end
    case (state_reg)
      ST_IDLE: begin
        if (start_pend_reg) begin
          start_pend_next = 1'b0;
          manual_next = 1'b1;
          conv_start_next = 1'b1;
          state_next = ST_CONV;
        end else if (sensor_en && ms_tick) begin
          manual_next = 1'b0;
          conv_start_next = 1'b1;
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (temp_sample_valid_i) begin
          state_next = ST_IDLE;
          if (manual_reg) begin
            temp_val_next = temp_sample_i;
            temp_rdy_evt = 1'b1;
            acc_next = 22'h00_0000;
            cnt_next = 11'h000;
          end else if (cnt_reg + 11'h001 == cnt_limit) begin
            temp_val_next = acc_sum[avg_shift +: 12];
            temp_rdy_evt = 1'b1;
            acc_next = 22'h00_0000;
            cnt_next = 11'h000;
          end else begin
            acc_next = acc_sum;
            cnt_next = cnt_reg + 11'h001;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (!nrst_i) begin
      crc_opt_reg <= `MCRT_RST_16;
      crc_start_reg <= 1'b0;
      temp_ctrl_reg <= 3'h0;
      start_pend_reg <= 1'b0;
      temp_val_reg <= 12'h000;
      gain_reg <= 14'h0000;
      conv_off_reg <= 7'h00;
      react_off_reg <= 1'b0;
      evt_status_reg <= 2'h0;
      evt_mask_reg <= 2'h0;
      prdata_reg <= `MCRT_RST_32;
      state_reg <= ST_IDLE;
      manual_reg <= 1'b0;
      acc_reg <= 22'h00_0000;
      cnt_reg <= 11'h000;
      tick_cnt_reg <= 17'h0_0000;
      conv_start_reg <= 1'b0;
    end else begin
      crc_opt_reg <= crc_opt_next;
      crc_start_reg <= wr & sel_crc_force & wdata[`MCRT_BIT_CRC_FORCE];
      temp_ctrl_reg <= temp_ctrl_next;
      start_pend_reg <= start_pend_next;
      temp_val_reg <= temp_val_next;
      gain_reg <= gain_next;
      conv_off_reg <= conv_off_next;
      react_off_reg <= react_off_next;
      evt_status_reg <= evt_status_next;
      evt_mask_reg <= evt_mask_next;
      prdata_reg <= prdata_next;
      state_reg <= state_next;
      manual_reg <= manual_next;
      acc_reg <= acc_next;
      cnt_reg <= cnt_next;
      tick_cnt_reg <= tick_cnt_next;
      conv_start_reg <= conv_start_next;
    end
  end

  // per-channel gain decode; codes 10 and 11 both mean x4
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : gen_gain
      wire [1:0] code = gain_reg[2*g+1:2*g];
      assign gain_shift_o[2*g+1:2*g] = (code == `MCRT_GAIN_X1) ? `MCRT_SHL_X1 :
        (code == `MCRT_GAIN_X2) ? `MCRT_SHL_X2 : `MCRT_SHL_X4;
    end
  endgenerate

  assign gain_code_o = gain_reg;
  assign converter_off_o = conv_off_reg;
  // order against the run bit is left to software
  assign total_reactive_off_o = react_off_reg;
  assign crc_select_o = crc_opt_reg;
  assign crc_start_o = crc_start_reg;
  // manual start powers the sensor for its one reading even if disabled
  assign temp_sensor_en_o = sensor_en | (state_reg == ST_CONV);
  assign temp_conv_start_o = conv_start_reg;
  assign irq_o = |(evt_status_reg & evt_mask_reg);
  assign prdata_o = prdata_reg;
  assign pready_o = access;
  assign pslverr_o = access & ~mapped;

endmodule

// ===== mcrt_regs_asserts.sv
// checker for mcrt_regs: register writes reach ports, launch pulses follow their writes
// assumes a bind to mcrt_regs, one clock, synchronous active-low reset
`timescale 1ns/1ps
module mcrt_regs_asserts (
  input wire clk_i,
  input wire nrst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [15:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [15:0] crc_select_o,
  input wire crc_start_o,
  input wire temp_sensor_en_o,
  input wire temp_conv_start_o,
  input wire [13:0] gain_code_o,
  input wire [13:0] gain_shift_o,
  input wire [6:0] converter_off_o,
  input wire total_reactive_off_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire wr = psel_i & penable_i & pwrite_i;
  wire [13:0] ix = paddr_i[15:2];
  reg [13:0] sh;
  integer k;
  // codes 10 and 11 both mean x4
  always @* begin
    for (k = 0; k < 7; k = k + 1)
      sh[2*k +: 2] = gain_code_o[2*k+1] ? 2'h2 : {1'b0, gain_code_o[2*k]};
  end
  property p_crc_sel; wr && ix == 14'h04b5 |=> crc_select_o == $past(pwdata_i[15:0]); endproperty
  a_crc_sel: assert property (p_crc_sel) else $error("crc select lost");
  // start only checked from idle: a busy sensor defers it
  property p_start; wr && ix == 14'h04b6 && pwdata_i[3] && !temp_sensor_en_o |-> ##[1:2]
    temp_conv_start_o; endproperty
  a_start: assert property (p_start) else $error("no conversion launch");
  property p_en; wr && ix == 14'h04b6 && pwdata_i[2] |=> temp_sensor_en_o; endproperty
  a_en: assert property (p_en) else $error("sensor not enabled");
  property p_gain; wr && ix == 14'h04b9 |=> gain_code_o == $past(pwdata_i[13:0]); endproperty
  a_gain: assert property (p_gain) else $error("gain lost");
  property p_shift; gain_shift_o == sh; endproperty
  a_shift: assert property (p_shift) else $error("gain decode wrong");
  property p_off; wr && ix == 14'h04ba |=> converter_off_o == $past(pwdata_i[6:0]); endproperty
  a_off: assert property (p_off) else $error("shutdown lost");
  property p_react; wr && ix == 14'h04e0 |=> total_reactive_off_o == $past(pwdata_i[0]);
  endproperty
  a_react: assert property (p_react) else $error("reactive off lost");
  property p_crc; wr && ix == 14'h04b4 && pwdata_i[0] |=> crc_start_o ##1 !crc_start_o;
  endproperty
  a_crc: assert property (p_crc) else $error("crc start pulse wrong");
endmodule

bind mcrt_regs mcrt_regs_asserts u_mcrt_regs_asserts (.clk_i, .nrst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .pwdata_i, .crc_select_o, .crc_start_o, .temp_sensor_en_o,
  .temp_conv_start_o, .gain_code_o, .gain_shift_o, .converter_off_o, .total_reactive_off_o);

// ===== tb_metering_config_register_tail.sv
// bench for mcrt_regs: apb traffic, crc and interrupt flow, temperature start and averaging
// assumes one 100 MHz clock; the bench plays the sensor and the crc engine
`timescale 1ns/1ps
module tb_metering_config_register_tail;
  localparam MS = 20;
  logic clk_i = 0, nrst_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic crc_done_i = 0, temp_sample_valid_i = 0;
  logic [15:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, d;
  logic [11:0] temp_sample_i = 0, smp = 0;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, irq_o, crc_start_o, temp_sensor_en_o, temp_conv_start_o;
  wire total_reactive_off_o;
  wire [15:0] crc_select_o;
  wire [13:0] gain_code_o, gain_shift_o;
  wire [6:0] converter_off_o;
  int fail_count = 0, tests_run = 0, rsp = 0, n;
  logic [32:0] expq[$];
  logic [15:0] ad [9] = '{16'h12d4, 16'h12e4, 16'h12e8, 16'h1380, 16'h13c4, 16'h12d0,
    16'h12d8, 16'h12dc, 16'h13c0};
  logic [15:0] mk [5] = '{16'hffff, 16'h3fff, 16'h007f, 16'h0001, 16'h0003};

  mcrt_regs #(.MS_CYCLES(MS)) u_mcrt_regs (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_o, .crc_select_o,
    .crc_start_o, .crc_done_i, .temp_sensor_en_o, .temp_conv_start_o, .temp_sample_valid_i,
    .temp_sample_i, .gain_code_o, .gain_shift_o, .converter_off_o, .total_reactive_off_o);

  initial forever #5 clk_i = ~clk_i;

  task chk(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [15:0] a, input logic [31:0] v);
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= v;
    @(posedge clk_i);
    penable_i <= 1;
    // no local limit: a hung slave is left to the watchdog
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    psel_i <= 0;
    penable_i <= 0;
  endtask

  task wr(input logic [15:0] a, input logic [31:0] v);
    apb(1, a, v);
  endtask

  task rd(input logic [15:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(0, a, 0);
  endtask

  task tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // read results land in the access cycle; error flag rides above the data
  always @(posedge clk_i) begin
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1)
      chk({pslverr_o, prdata_o}, expq.pop_front());
  end

  // sensor stand-in: answers three cycles after each launch, line busy otherwise
  always @(posedge clk_i) begin
    temp_sample_valid_i <= rsp == 1;
    temp_sample_i <= rsp == 1 ? smp : ~smp;
    if (temp_conv_start_o === 1'b1) rsp <= 3;
    else if (rsp != 0) rsp <= rsp - 1;
  end

  initial begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(48));
    repeat (8) @(posedge clk_i);
    nrst_i <= 1;
    foreach (ad[i]) rd(ad[i], 0);
    repeat (3) foreach (mk[i]) begin
      d = $urandom;
      wr(ad[i], d);
      rd(ad[i], d & mk[i]);
    end
    rd(16'h12e0, 33'h1_0000_0000);
    for (n = 0; n < 9; n++) begin
      wr(16'h12d4, 32'h1 << n);
      #1 chk(crc_select_o, 16'h1 << n);
    end
    wr(16'h12e4, 16'h1b1b);
    wr(16'h12e8, 16'hff81);
    wr(16'h1380, 16'hfffe);
    #1 chk(gain_shift_o, 14'h1a1a);
    chk(gain_code_o, 14'h1b1b);
    chk(converter_off_o, 7'h01);
    chk(total_reactive_off_o, 0);
    wr(16'h1380, 1);
    #1 chk(total_reactive_off_o, 1);
    wr(16'h13c4, 0);
    wr(16'h12d0, 1);
    #1 chk(crc_start_o, 1);
    @(posedge clk_i);
    crc_done_i <= 1;
    @(posedge clk_i);
    crc_done_i <= 0;
    rd(16'h13c0, 2);
    #1 chk(irq_o, 0);
    wr(16'h13c4, 2);
    #1 chk(irq_o, 1);
    wr(16'h13c0, 2);
    #1 chk(irq_o, 0);
    smp <= 12'($urandom);
    wr(16'h12d8, 8);
    @(posedge clk_i);
    #1 chk(temp_conv_start_o, 1);
    repeat (MS) @(posedge clk_i);
    rd(16'h13c0, 1);
    rd(16'h12dc, smp);
    rd(16'h12d8, 0);
    #1 chk(temp_sensor_en_o, 0);
    // constant samples: a wrong shift halves or doubles the average
    for (n = 0; n < 4; n++) begin
      smp <= 12'($urandom);
      wr(16'h12d8, 4 + n);
      repeat (10) @(posedge clk_i);
      wr(16'h13c0, 1);
      if (n > 0) begin
        repeat (((1 << (n + 7)) - 1) * MS - 20) @(posedge clk_i);
        rd(16'h13c0, 0);
      end
      repeat (MS + 20) @(posedge clk_i);
      rd(16'h13c0, 1);
      rd(16'h12dc, smp);
    end
    wr(16'h12d8, 0);
    repeat (4) @(posedge clk_i);
    // mid-run reset with fields set and a conversion maybe in flight
    nrst_i <= 0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1;
    foreach (ad[i]) rd(ad[i], 0);
    #1 chk(irq_o, 0);
    tally_and_finish();
  end
endmodule
